// ---- pmaam_pin_model.sv ----
`default_nettype none
// ----------------------------------------
// alert wire with its pull-up resistor
// ----------------------------------------
module pmaam_pin_model (
  input  wire logic alert_oe,
  output logic      alert_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // released wire is pulled high
  assign alert_pin = alert_oe ? 1'b0 : 1'b1;
endmodule : pmaam_pin_model
`default_nettype wire

// ---- pmaam_pkg.sv ----
`default_nettype none
package pmaam_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned TICK_NS       = 1000;
  localparam int unsigned TICK_CYC      = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] ADR_CONFIG = 8'h00;
  localparam logic [7:0] ADR_ADC    = 8'h04;
  localparam logic [7:0] ADR_DIAG   = 8'h08;
  localparam logic [7:0] ADR_CUR_LO = 8'h0C;
  localparam logic [7:0] ADR_CUR_HI = 8'h10;
  localparam logic [7:0] ADR_BUS_HI = 8'h14;
  localparam logic [7:0] ADR_BUS_LO = 8'h18;
  localparam logic [7:0] ADR_TEMP   = 8'h1C;
  localparam logic [7:0] ADR_PWR    = 8'h20;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [15:0] RST_ADC    = 16'h7000;
  localparam logic [15:0] RST_CUR_LO = 16'h8000;
  localparam logic [15:0] RST_CUR_HI = 16'h7FFF;
  localparam logic [15:0] RST_BUS_HI = 16'h7FFF;
  localparam logic [15:0] RST_BUS_LO = 16'h0000;
  localparam logic [15:0] RST_TEMP   = 16'hFFFF;
  localparam logic [15:0] RST_PWR    = 16'h7FFF;
  localparam logic [3:0]  RST_CTL    = 4'h0;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int unsigned CFG_RST_BIT  = 15;
  localparam int unsigned ADC_MODE_LSB = 12;
  localparam int unsigned ADC_BCT_LSB  = 9;
  localparam int unsigned ADC_SCT_LSB  = 6;
  localparam int unsigned ADC_TCT_LSB  = 3;
  localparam int unsigned ADC_AVG_LSB  = 0;
  localparam int unsigned MODE_CUR_BIT = 0;
  localparam int unsigned MODE_BUS_BIT = 1;
  localparam int unsigned MODE_CON_BIT = 2;
  localparam int unsigned DG_DONE_BIT  = 10;
  localparam int unsigned DG_CTL_LSB   = 12;
  // ----------------------------------------
  // types and tables
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_TEMP  = 4'h2,
    ST_SHUNT = 4'h4,
    ST_BUS   = 4'h8
  } pmaam_state_e;

  function automatic logic [12:0] ct_us(input logic [2:0] code);
    case (code)
      3'h0:    ct_us = 13'h0032;
      3'h1:    ct_us = 13'h0054;
      3'h2:    ct_us = 13'h0096;
      3'h3:    ct_us = 13'h0118;
      3'h4:    ct_us = 13'h021C;
      3'h5:    ct_us = 13'h041C;
      3'h6:    ct_us = 13'h081A;
      default: ct_us = 13'h1018;
    endcase
  endfunction : ct_us

  function automatic logic [10:0] avg_n(input logic [2:0] code);
    case (code)
      3'h0:    avg_n = 11'h001;
      3'h1:    avg_n = 11'h004;
      3'h2:    avg_n = 11'h010;
      3'h3:    avg_n = 11'h040;
      3'h4:    avg_n = 11'h080;
      3'h5:    avg_n = 11'h100;
      3'h6:    avg_n = 11'h200;
      default: avg_n = 11'h400;
    endcase
  endfunction : avg_n
endpackage : pmaam_pkg
`default_nettype wire

// ---- pmaam_top.sv ----
// The implementer's own choices: the register offsets and the Wishbone interface to the registers.
`default_nettype none
// Overview of operation
// - each conversion step ends with a settled result after one selected period; a step opened by a start write can end up to one tick early
// - bus conversion period selects on its own, 50 us to 4.12 ms
// - current result takes temperature period plus shunt period
// - averaging count 1 to 1024, same count for every enabled channel
// - results compare against limits; a passed limit asserts the alert
// - with hold enabled the alert stays asserted after conditions clear
// - reading diagnostic status releases the held alert
// - with done signalling enabled the alert asserts when a sequence completes
// - done flag records every completed sequence regardless of done signalling
// - averaged compare checks limits against averaged results at sequence end
// - alert active low after reset; invert bit makes it active high; open drain
// - arithmetic overflow sets a status flag that never drives the alert
// - trim memory status reads one while the trim storage is healthy
// - energy and charge overflows set own flags, not driving the alert
// - shutdown mode stops conversions while registers stay accessible
// - shutdown holds until a triggered or continuous mode is written
// - a triggered sequence completes and then returns to shutdown
// - power-on reset returns every register to its default
// - config reset bit resets registers exactly like power-on reset
// - the internal time base paces conversions and the elapsed time count
// - done flag sets only after all channels and all averages finish
// - done flag clears on non-shutdown converter config write or status read
module pmaam_top #(
  parameter int unsigned TICK_CYC = pmaam_pkg::TICK_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [15:0] raw_current,
  input  wire logic [15:0] raw_bus,
  input  wire logic [15:0] raw_temp,
  input  wire logic [15:0] avg_current,
  input  wire logic [15:0] avg_bus,
  input  wire logic [15:0] avg_temp,
  input  wire logic [15:0] avg_power,
  input  wire logic        math_ovf_evt,
  input  wire logic        energy_ovf_evt,
  input  wire logic        charge_ovf_evt,
  input  wire logic        trim_memory_ok,
  output logic             alert_out,
  output logic             alert_oe,
  output logic             sample_strobe,
  output logic             seq_done,
  output logic             conv_busy,
  output logic      [31:0] elapsed_us
);
  if (TICK_CYC < 1 || TICK_CYC > 65535)
  begin : g_bad_tick
    $error("TICK_CYC out of range");
  end

  // ----------------------------------------
  // registers and reset
  // ----------------------------------------
  logic               soft_rst_r;
  logic               sreset;
  logic [15:0]        adc_cfg_r;
  logic [3:0]         ctl_r;
  logic [15:0]        current_low_threshold, current_high_threshold;
  logic [15:0]        bus_high_threshold, bus_low_threshold, temp_thr_r, power_high_threshold;
  logic               acc, wr, rd_diag, wr_adc, start, stop;
  logic [15:0]        wval, rd_val;
  logic [2:0]         new_mode;
  logic [15:0]        diag_val;
  logic               hold_output_enable, done_signal_enable;
  logic               averaged_compare_enable, output_sense_invert;

  assign sreset = rst | soft_rst_r;
  assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = acc & wb_we_i;
  assign rd_diag = acc & ~wb_we_i & (wb_adr_i == pmaam_pkg::ADR_DIAG);
  assign hold_output_enable = ctl_r[3];
  assign done_signal_enable = ctl_r[2];
  assign output_sense_invert = ctl_r[1];
  assign averaged_compare_enable = ctl_r[0];

  function automatic logic [15:0] merge(input logic [15:0] old);
    merge = {wb_sel_i[1] ? wb_dat_i[15:8] : old[15:8], wb_sel_i[0] ? wb_dat_i[7:0] : old[7:0]};
  endfunction : merge

  assign wval = merge(adc_cfg_r);
  assign wr_adc = wr & (wb_adr_i == pmaam_pkg::ADR_ADC);
  assign new_mode = wval[pmaam_pkg::ADC_MODE_LSB +: 3];
  assign start = wr_adc & (new_mode[1:0] != 2'h0);
  assign stop = wr_adc & ~start;

  always_ff @(posedge sys_clk)
  begin
    if (sreset)
      soft_rst_r <= 1'b0;
    else
      soft_rst_r <= wr & (wb_adr_i == pmaam_pkg::ADR_CONFIG) & wb_sel_i[1]
                    & wb_dat_i[pmaam_pkg::CFG_RST_BIT];
  end

  always_ff @(posedge sys_clk)
  begin
    if (sreset)
    begin
      adc_cfg_r <= pmaam_pkg::RST_ADC;
      ctl_r <= pmaam_pkg::RST_CTL;
      current_low_threshold <= pmaam_pkg::RST_CUR_LO;
      current_high_threshold <= pmaam_pkg::RST_CUR_HI;
      bus_high_threshold <= pmaam_pkg::RST_BUS_HI;
      bus_low_threshold <= pmaam_pkg::RST_BUS_LO;
      temp_thr_r <= pmaam_pkg::RST_TEMP;
      power_high_threshold <= pmaam_pkg::RST_PWR;
    end
    else if (wr)
    begin
      if (wb_adr_i == pmaam_pkg::ADR_ADC)
        adc_cfg_r <= wval;
      else if (wb_adr_i == pmaam_pkg::ADR_DIAG && wb_sel_i[1])
        ctl_r <= wb_dat_i[pmaam_pkg::DG_CTL_LSB +: 4];
      else if (wb_adr_i == pmaam_pkg::ADR_CUR_LO)
        current_low_threshold <= merge(current_low_threshold);
      else if (wb_adr_i == pmaam_pkg::ADR_CUR_HI)
        current_high_threshold <= merge(current_high_threshold);
      else if (wb_adr_i == pmaam_pkg::ADR_BUS_HI)
        bus_high_threshold <= merge(bus_high_threshold);
      else if (wb_adr_i == pmaam_pkg::ADR_BUS_LO)
        bus_low_threshold <= merge(bus_low_threshold);
      else if (wb_adr_i == pmaam_pkg::ADR_TEMP)
        temp_thr_r <= merge(temp_thr_r);
      else if (wb_adr_i == pmaam_pkg::ADR_PWR)
        power_high_threshold <= merge(power_high_threshold);
    end
  end

  // ----------------------------------------
  // time base and conversion sequencer
  // ----------------------------------------
  logic [15:0]               tick_cnt_r;
  logic                      tick_r;
  logic [12:0]               us_cnt_r;
  logic [12:0]               cur_ct;
  logic [10:0]               avg_cnt_r;
  logic [10:0]               navg;
  pmaam_pkg::pmaam_state_e   state_r;
  logic                      step_end, last_step, seq_end, done_pulse;
  logic                      m_cur, m_bus, m_con;

  assign m_cur = adc_cfg_r[pmaam_pkg::ADC_MODE_LSB + pmaam_pkg::MODE_CUR_BIT];
  assign m_bus = adc_cfg_r[pmaam_pkg::ADC_MODE_LSB + pmaam_pkg::MODE_BUS_BIT];
  assign m_con = adc_cfg_r[pmaam_pkg::ADC_MODE_LSB + pmaam_pkg::MODE_CON_BIT];
  assign navg = pmaam_pkg::avg_n(adc_cfg_r[pmaam_pkg::ADC_AVG_LSB +: 3]);

  always_ff @(posedge sys_clk)
  begin
    if (sreset || tick_cnt_r == 16'(TICK_CYC - 1))
      tick_cnt_r <= 16'h0000;
    else
      tick_cnt_r <= tick_cnt_r + 16'h0001;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sreset)
      tick_r <= 1'b0;
    else
      tick_r <= (tick_cnt_r == 16'(TICK_CYC - 1));
  end

  always_comb
  begin
    case (state_r)
      pmaam_pkg::ST_TEMP:  cur_ct = pmaam_pkg::ct_us(adc_cfg_r[pmaam_pkg::ADC_TCT_LSB +: 3]);
      pmaam_pkg::ST_SHUNT: cur_ct = pmaam_pkg::ct_us(adc_cfg_r[pmaam_pkg::ADC_SCT_LSB +: 3]);
      default:             cur_ct = pmaam_pkg::ct_us(adc_cfg_r[pmaam_pkg::ADC_BCT_LSB +: 3]);
    endcase
  end

  // a step closes one full period after it opened, or up to one tick sooner if a start write opened it, filter already settled
  assign step_end = tick_r & (us_cnt_r == cur_ct - 13'h0001) & (state_r != pmaam_pkg::ST_IDLE);
  assign last_step = (state_r == pmaam_pkg::ST_BUS) | ((state_r == pmaam_pkg::ST_SHUNT) & ~m_bus);
  assign seq_end = step_end & last_step;
  assign done_pulse = seq_end & (avg_cnt_r == navg - 11'h001);

  always_ff @(posedge sys_clk)
  begin
    if (sreset || start || step_end)
      us_cnt_r <= 13'h0000;
    else if (tick_r)
      us_cnt_r <= us_cnt_r + 13'h0001;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sreset || start || stop || done_pulse)
      avg_cnt_r <= 11'h000;
    else if (seq_end)
      avg_cnt_r <= avg_cnt_r + 11'h001;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sreset)
      state_r <= pmaam_pkg::ST_IDLE;
    else if (start)
      state_r <= new_mode[pmaam_pkg::MODE_CUR_BIT] ? pmaam_pkg::ST_TEMP : pmaam_pkg::ST_BUS;
    else if (stop)
      state_r <= pmaam_pkg::ST_IDLE;
    else if (step_end)
    begin
      if (state_r == pmaam_pkg::ST_TEMP)
        state_r <= pmaam_pkg::ST_SHUNT;
      else if (!last_step)
        state_r <= pmaam_pkg::ST_BUS;
      else if (done_pulse && !m_con)
        state_r <= pmaam_pkg::ST_IDLE;
      else
        state_r <= m_cur ? pmaam_pkg::ST_TEMP : pmaam_pkg::ST_BUS;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sreset)
    begin
      sample_strobe <= 1'b0;
      seq_done <= 1'b0;
      conv_busy <= 1'b0;
      elapsed_us <= 32'h0000_0000;
    end
    else
    begin
      sample_strobe <= step_end;
      seq_done <= done_pulse;
      conv_busy <= (state_r != pmaam_pkg::ST_IDLE);
      if (tick_r && m_con && state_r != pmaam_pkg::ST_IDLE)
        elapsed_us <= elapsed_us + 32'h0000_0001;
    end
  end

  // ----------------------------------------
  // limit comparison
  // ----------------------------------------
  logic [5:0] lim_r;
  logic       cmp_cur, cmp_bus, cmp_tmp;
  logic [15:0] v_cur, v_bus, v_tmp;

  function automatic logic [15:0] pos(input logic [15:0] v);
    pos = v[15] ? 16'h0000 : v;
  endfunction : pos

  assign cmp_cur = averaged_compare_enable ? done_pulse & m_cur
                                           : step_end & (state_r == pmaam_pkg::ST_SHUNT);
  assign cmp_bus = averaged_compare_enable ? done_pulse & m_bus
                                           : step_end & (state_r == pmaam_pkg::ST_BUS);
  assign cmp_tmp = averaged_compare_enable ? done_pulse & m_cur
                                           : step_end & (state_r == pmaam_pkg::ST_TEMP);
  assign v_cur = averaged_compare_enable ? avg_current : raw_current;
  assign v_bus = averaged_compare_enable ? avg_bus : raw_bus;
  assign v_tmp = averaged_compare_enable ? avg_temp : raw_temp;

  // lim_r: 0 power_high_flag 1 bus_low_flag 2 bus_high_flag 3 current_low_flag 4 current_high_flag 5 temp_high_flag
  always_ff @(posedge sys_clk)
  begin
    if (sreset)
      lim_r <= 6'h00;
    else
    begin
      if (cmp_cur)
      begin
        lim_r[3] <= $signed(v_cur) < $signed(current_low_threshold);
        lim_r[4] <= $signed(v_cur) > $signed(current_high_threshold);
      end
      if (cmp_bus)
      begin
        lim_r[2] <= pos(v_bus) > bus_high_threshold;
        lim_r[1] <= pos(v_bus) < bus_low_threshold;
      end
      if (cmp_tmp)
        lim_r[5] <= pos(v_tmp) > temp_thr_r;
      if (done_pulse && m_bus)
        lim_r[0] <= $signed(avg_power) > $signed(power_high_threshold);
    end
  end

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  logic done_flag, arithmetic_overflow_flag, energy_accum_overflow_flag, charge_accum_overflow_flag;

  always_ff @(posedge sys_clk)
  begin
    if (sreset)
      done_flag <= 1'b0;
    else if (done_pulse)
      done_flag <= 1'b1;
    else if (rd_diag || start)
      done_flag <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sreset)
    begin
      arithmetic_overflow_flag <= 1'b0;
      energy_accum_overflow_flag <= 1'b0;
      charge_accum_overflow_flag <= 1'b0;
    end
    else
    begin
      arithmetic_overflow_flag <= math_ovf_evt | (arithmetic_overflow_flag & ~rd_diag);
      energy_accum_overflow_flag <= energy_ovf_evt | (energy_accum_overflow_flag & ~rd_diag);
      charge_accum_overflow_flag <= charge_ovf_evt | (charge_accum_overflow_flag & ~rd_diag);
    end
  end

  assign diag_val = {ctl_r, 1'b0, done_flag, charge_accum_overflow_flag, energy_accum_overflow_flag,
                     arithmetic_overflow_flag, trim_memory_ok, lim_r};

  // ----------------------------------------
  // alert output
  // ----------------------------------------
  logic alert_raw, hold_r, alert_act;

  assign alert_raw = (|lim_r) | (done_signal_enable & done_flag);
  assign alert_act = alert_raw | (hold_output_enable & hold_r);

  always_ff @(posedge sys_clk)
  begin
    if (sreset)
      hold_r <= 1'b0;
    else if (alert_raw)
      hold_r <= 1'b1;
    else if (rd_diag || !hold_output_enable)
      hold_r <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sreset)
    begin
      alert_out <= 1'b0;
      alert_oe <= 1'b0;
    end
    else
    begin
      alert_out <= 1'b0;
      alert_oe <= alert_act ^ output_sense_invert;
    end
  end

  // ----------------------------------------
  // wishbone slave
  // ----------------------------------------
  always_comb
  begin
    if (wb_adr_i == pmaam_pkg::ADR_ADC)
      rd_val = adc_cfg_r;
    else if (wb_adr_i == pmaam_pkg::ADR_DIAG)
      rd_val = diag_val;
    else if (wb_adr_i == pmaam_pkg::ADR_CUR_LO)
      rd_val = current_low_threshold;
    else if (wb_adr_i == pmaam_pkg::ADR_CUR_HI)
      rd_val = current_high_threshold;
    else if (wb_adr_i == pmaam_pkg::ADR_BUS_HI)
      rd_val = bus_high_threshold;
    else if (wb_adr_i == pmaam_pkg::ADR_BUS_LO)
      rd_val = bus_low_threshold;
    else if (wb_adr_i == pmaam_pkg::ADR_TEMP)
      rd_val = temp_thr_r;
    else if (wb_adr_i == pmaam_pkg::ADR_PWR)
      rd_val = power_high_threshold;
    else
      rd_val = 16'h0000;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sreset)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= acc;
      if (acc && !wb_we_i)
        wb_dat_o <= {16'h0000, rd_val};
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_done_sets;
    @(posedge sys_clk) disable iff (sreset) done_pulse |=> done_flag;
  endproperty
  a_done_sets: assert property (p_done_sets) else $error("done flag missed a completion");

  property p_done_clears;
    @(posedge sys_clk) disable iff (sreset) (rd_diag && !done_pulse) |=> !done_flag;
  endproperty
  a_done_clears: assert property (p_done_clears) else $error("done flag survived status read");

  property p_polarity;
    @(posedge sys_clk) disable iff (sreset) 1'b1 |=> (alert_oe == ($past(alert_act) ^ $past(output_sense_invert)));
  endproperty
  a_polarity: assert property (p_polarity) else $error("alert pin level wrong for polarity");

  property p_hold;
    @(posedge sys_clk) disable iff (sreset)
      (hold_output_enable && alert_act && !rd_diag && !wr) |=> alert_act;
  endproperty
  a_hold: assert property (p_hold) else $error("held alert dropped without status read");

  property p_done_alert;
    @(posedge sys_clk) disable iff (sreset)
      (done_pulse && done_signal_enable && !wr) |=> ##1 alert_oe != $past(output_sense_invert);
  endproperty
  a_done_alert: assert property (p_done_alert) else $error("completion did not assert alert");

  property p_trig_return;
    @(posedge sys_clk) disable iff (sreset) (done_pulse && !m_con && !wr_adc) |=> state_r == pmaam_pkg::ST_IDLE;
  endproperty
  a_trig_return: assert property (p_trig_return) else $error("triggered sequence did not return to shutdown");

  property p_shutdown_stays;
    @(posedge sys_clk) disable iff (sreset) (state_r == pmaam_pkg::ST_IDLE && !start) |=> state_r == pmaam_pkg::ST_IDLE;
  endproperty
  a_shutdown_stays: assert property (p_shutdown_stays) else $error("left shutdown without command");

  property p_soft_reset;
    @(posedge sys_clk) disable iff (rst)
      soft_rst_r |=> (adc_cfg_r == pmaam_pkg::RST_ADC && current_low_threshold == pmaam_pkg::RST_CUR_LO && !done_flag);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("reset bit did not restore defaults");

  property p_avg_bound;
    @(posedge sys_clk) disable iff (sreset) avg_cnt_r < navg;
  endproperty
  a_avg_bound: assert property (p_avg_bound) else $error("average count exceeded selection");
endmodule : pmaam_top
`default_nettype wire

// ---- pmaam_top_tb.sv ----
`default_nettype none
module pmaam_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk, rst, cyc, stb, we, mo, eo, co, trim;
  logic        ack, a_out, a_oe, strb, done, busy, pin;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, dat_o, el, el_q;
  logic [15:0] rv;
  logic [15:0] lim_rst [6];
  int          failures, n_checks, cyc_n, n_str;

  pmaam_top #(.TICK_CYC(2)) dut (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .raw_current(rv), .raw_bus(rv), .raw_temp(rv), .avg_current(rv), .avg_bus(rv), .avg_temp(rv),
    .avg_power(rv), .math_ovf_evt(mo), .energy_ovf_evt(eo), .charge_ovf_evt(co),
    .trim_memory_ok(trim), .alert_out(a_out), .alert_oe(a_oe), .sample_strobe(strb),
    .seq_done(done), .conv_busy(busy), .elapsed_us(el));
  pmaam_pin_model pin_m (.alert_oe(a_oe), .alert_pin(pin));

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic summarize();
    if (failures == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [15:0] d);
    int i;
    @(posedge sys_clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= s;
    wdat <= {16'h0000, d};
    for (i = 0; i < 16 && ack !== 1'b1; i++)
      @(posedge sys_clk);
    if (i == 16)
    begin
      failures++;
      summarize();
    end
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge sys_clk);
  endtask : wb

  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 4'h3, 16'h0000);
  endtask : rd

  // ----------------------------------------
  // start a sequence, count strobes and cycles to completion
  // ----------------------------------------
  task automatic conv(input logic [15:0] code, input int ns, input int lo, input int hi);
    wb(1'b1, pmaam_pkg::ADR_ADC, 4'h3, code);
    cyc_n = 0;
    n_str = 0;
    while (done !== 1'b1 && cyc_n < 4000)
    begin
      @(posedge sys_clk);
      cyc_n++;
      if (strb === 1'b1)
        n_str++;
    end
    if (cyc_n >= 4000)
    begin
      failures++;
      summarize();
    end
    chk("strobes", ns, n_str);
    chk("seq_time", 1, (cyc_n >= lo && cyc_n <= hi));
    repeat (3) @(posedge sys_clk);
    chk("busy_after", 1'b0, busy);
  endtask : conv

  initial
  begin
    lim_rst = '{pmaam_pkg::RST_CUR_LO, pmaam_pkg::RST_CUR_HI, pmaam_pkg::RST_BUS_HI,
                pmaam_pkg::RST_BUS_LO, pmaam_pkg::RST_TEMP, pmaam_pkg::RST_PWR};
    {rst, cyc, stb, we, mo, eo, co, trim} = 8'h81;
    {adr, sel, wdat} = '0;
    rv = 16'h0100;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    for (int k = 0; k < 6; k++)
    begin
      rd(8'h0C + 8'(4 * k));
      chk("limit_rst", {16'h0000, lim_rst[k]}, rdat);
    end
    rd(pmaam_pkg::ADR_DIAG);
    chk("status_rst", 32'h0000_0040, rdat);
    rd(8'h3C);
    chk("unmapped", 32'h0000_0000, rdat);
    chk("pin_idle", 1'b1, pin);
    chk("pin_data", 1'b0, a_out);
    conv(16'h1000, 2, 196, 204);
    rd(pmaam_pkg::ADR_DIAG);
    chk("done_set", 1'b1, rdat[10]);
    rd(pmaam_pkg::ADR_DIAG);
    chk("done_rdclr", 1'b0, rdat[10]);
    conv(16'h1001, 8, 796, 804);
    wb(1'b1, pmaam_pkg::ADR_ADC, 4'h3, 16'h5000);
    repeat (250) @(posedge sys_clk);
    chk("run_busy", 1'b1, busy);
    wb(1'b1, pmaam_pkg::ADR_ADC, 4'h3, 16'h0000);
    el_q = el;
    repeat (40) @(posedge sys_clk);
    chk("sd_busy", 1'b0, busy);
    chk("elapsed_run", 1, el_q != 32'h0000_0000);
    chk("elapsed_stop", el_q, el);
    wb(1'b1, pmaam_pkg::ADR_CUR_HI, 4'h3, 16'h0050);
    rd(pmaam_pkg::ADR_CUR_HI);
    chk("sd_regs", 32'h0000_0050, rdat);
    rd(pmaam_pkg::ADR_DIAG);
    chk("done_sdkeep", 1'b1, rdat[10]);
    conv(16'h1000, 2, 196, 204);
    repeat (3) @(posedge sys_clk);
    chk("pin_limit", 1'b0, pin);
    wb(1'b1, pmaam_pkg::ADR_DIAG, 4'h2, 16'h2000);
    repeat (3) @(posedge sys_clk);
    chk("pin_inv", 1'b1, pin);
    wb(1'b1, pmaam_pkg::ADR_DIAG, 4'h2, 16'h8000);
    wb(1'b1, pmaam_pkg::ADR_CUR_HI, 4'h3, 16'h7FFF);
    conv(16'h1000, 2, 196, 204);
    chk("pin_held", 1'b0, pin);
    rd(pmaam_pkg::ADR_DIAG);
    chk("cur_hi_clr", 1'b0, rdat[4]);
    repeat (3) @(posedge sys_clk);
    chk("pin_release", 1'b1, pin);
    wb(1'b1, pmaam_pkg::ADR_DIAG, 4'h2, 16'h4000);
    conv(16'h1000, 2, 196, 204);
    chk("pin_done", 1'b0, pin);
    rd(pmaam_pkg::ADR_DIAG);
    repeat (3) @(posedge sys_clk);
    chk("pin_done_clr", 1'b1, pin);
    wb(1'b1, pmaam_pkg::ADR_DIAG, 4'h2, 16'h0000);
    {mo, eo, co} <= 3'h7;
    @(posedge sys_clk);
    {mo, eo, co} <= 3'h0;
    trim <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("pin_ovf", 1'b1, pin);
    rd(pmaam_pkg::ADR_DIAG);
    chk("ovf_flags", 3'h7, rdat[9:7]);
    chk("trim_bad", 1'b0, rdat[6]);
    trim <= 1'b1;
    wb(1'b1, pmaam_pkg::ADR_DIAG, 4'h2, 16'h1000);
    wb(1'b1, pmaam_pkg::ADR_BUS_LO, 4'h3, 16'h0200);
    conv(16'h2200, 1, 164, 170);
    chk("pin_bus", 1'b0, pin);
    rd(pmaam_pkg::ADR_DIAG);
    chk("bus_lo_avg", 32'h0000_1442, rdat);
    wb(1'b1, pmaam_pkg::ADR_CUR_HI, 4'h3, 16'h1234);
    wb(1'b1, pmaam_pkg::ADR_CONFIG, 4'h2, 16'h8000);
    repeat (2) @(posedge sys_clk);
    rd(pmaam_pkg::ADR_CUR_HI);
    chk("soft_rst", {16'h0000, pmaam_pkg::RST_CUR_HI}, rdat);
    rd(pmaam_pkg::ADR_DIAG);
    chk("soft_rst_status", 32'h0000_0040, rdat);
    summarize();
  end
endmodule : pmaam_top_tb
`default_nettype wire
